// ===== design/dfmnco_top.sv
// Function
// - AB offset added before sin/cos
// - Offset plus accumulator top indexes lookup
// - CD offset added before sin/cos
// - AB offset write raises sync if enabled
// - AB sync loads offset and frequency together
// - AB frequency writes stay staged
// - CD sync loads offset and frequency together
// - CD frequency writes staged; offset last
// - AB frequency low/high at consecutive addresses
// - CD frequency low/high at consecutive addresses
// - Frequency word signed, step Fs/2^32
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module dfmnco_top
    import dfmnco_pkg::*;
(
    input wire logic pclk, // Clock, 20 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [31:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    output dfmnco_pkg::dfmnco_out_t ab_nco, // AB oscillator output
    output dfmnco_pkg::dfmnco_out_t cd_nco, // CD oscillator output
    output logic ab_sync, // AB auto-sync pulse
    output logic cd_sync // CD auto-sync pulse
);
    import dfmnco_pkg::*;

    // Staged register values
    logic [15:0] ab_phase_offset_word_q;
    logic [15:0] ab_phase_offset_word_d;
    logic [15:0] cd_phase_offset_word_q;
    logic [15:0] cd_phase_offset_word_d;
    logic [15:0] ab_freq_word_low_q;
    logic [15:0] ab_freq_word_low_d;
    logic [15:0] ab_freq_word_high_q;
    logic [15:0] ab_freq_word_high_d;
    logic [15:0] cd_freq_word_low_q;
    logic [15:0] cd_freq_word_low_d;
    logic [15:0] cd_freq_word_high_q;
    logic [15:0] cd_freq_word_high_d;
    logic [2:0] sync_source_config_q;
    logic [2:0] sync_source_config_d;
    // Active mixer settings
    dfmnco_set_t ab_act_q;
    dfmnco_set_t ab_act_d;
    dfmnco_set_t cd_act_q;
    dfmnco_set_t cd_act_d;
    logic ab_sync_q;
    logic ab_sync_d;
    logic cd_sync_q;
    logic cd_sync_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pslverr_q;
    logic pslverr_d;

    logic setup;
    logic wr_acc;
    logic aligned;
    logic [7:0] idx;
    logic mapped;
    logic [31:0] ab_acc;
    logic [31:0] cd_acc;
    logic [15:0] wlow;

    // Decode: word index from byte address, unmapped above
    assign aligned = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h0);
    assign idx = paddr[9:2];
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite && mapped;
    assign pready = 1'b1;

    always_comb
    begin
        case (idx)
            DFMNCO_IDX_AB_PHASE, DFMNCO_IDX_CD_PHASE,
            DFMNCO_IDX_AB_FLO, DFMNCO_IDX_AB_FHI,
            DFMNCO_IDX_CD_FLO, DFMNCO_IDX_CD_FHI,
            DFMNCO_IDX_CTRL, DFMNCO_IDX_AB_ACT,
            DFMNCO_IDX_CD_ACT, DFMNCO_IDX_STAT: mapped = aligned;
            default: mapped = 1'b0;
        endcase
    end

    // Byte-lane merge helper for 16-bit registers
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] st);
        logic [15:0] r;
        r = old;
        if (st[0])
            r[7:0] = wd[7:0];
        if (st[1])
            r[15:8] = wd[15:8];
        return r;
    endfunction : merge16

    // Staged register writes; frequency halves never touch active
    always_comb
    begin
        wlow = 16'h0000;
        ab_phase_offset_word_d = ab_phase_offset_word_q;
        cd_phase_offset_word_d = cd_phase_offset_word_q;
        ab_freq_word_low_d = ab_freq_word_low_q;
        ab_freq_word_high_d = ab_freq_word_high_q;
        cd_freq_word_low_d = cd_freq_word_low_q;
        cd_freq_word_high_d = cd_freq_word_high_q;
        sync_source_config_d = sync_source_config_q;
        if (wr_acc)
        begin
            case (idx)
                DFMNCO_IDX_AB_PHASE: ab_phase_offset_word_d =
                    merge16(ab_phase_offset_word_q, pwdata, pstrb);
                DFMNCO_IDX_CD_PHASE: cd_phase_offset_word_d =
                    merge16(cd_phase_offset_word_q, pwdata, pstrb);
                DFMNCO_IDX_AB_FLO: ab_freq_word_low_d =
                    merge16(ab_freq_word_low_q, pwdata, pstrb);
                DFMNCO_IDX_AB_FHI: ab_freq_word_high_d =
                    merge16(ab_freq_word_high_q, pwdata, pstrb);
                DFMNCO_IDX_CD_FLO: cd_freq_word_low_d =
                    merge16(cd_freq_word_low_q, pwdata, pstrb);
                DFMNCO_IDX_CD_FHI: cd_freq_word_high_d =
                    merge16(cd_freq_word_high_q, pwdata, pstrb);
                DFMNCO_IDX_CTRL:
                begin
                    wlow = merge16({13'h0, sync_source_config_q},
                        pwdata, pstrb);
                    sync_source_config_d = wlow[2:0];
                end
                default: wlow = 16'h0000;
            endcase
        end
    end

    // Auto-sync: offset write, if enabled, loads all three at once
    always_comb
    begin
        ab_sync_d = wr_acc && (idx == DFMNCO_IDX_AB_PHASE)
            && sync_source_config_q[DFMNCO_CTRL_SYNC_AB_BIT];
        cd_sync_d = wr_acc && (idx == DFMNCO_IDX_CD_PHASE)
            && sync_source_config_q[DFMNCO_CTRL_SYNC_CD_BIT];
        ab_act_d = ab_act_q;
        cd_act_d = cd_act_q;
        if (ab_sync_d)
        begin
            ab_act_d.shift = ab_phase_offset_word_d;
            ab_act_d.step = {ab_freq_word_high_q, ab_freq_word_low_q};
        end
        if (cd_sync_d)
        begin
            cd_act_d.shift = cd_phase_offset_word_d;
            cd_act_d.step = {cd_freq_word_high_q, cd_freq_word_low_q};
        end
    end

    // Read mux and error answer, captured in the setup cycle
    always_comb
    begin
        prdata_d = prdata_q;
        pslverr_d = pslverr_q;
        if (setup)
        begin
            pslverr_d = !mapped;
            prdata_d = 32'h0000_0000;
            if (mapped && !pwrite)
            begin
                case (idx)
                    DFMNCO_IDX_AB_PHASE:
                        prdata_d = {16'h0, ab_phase_offset_word_q};
                    DFMNCO_IDX_CD_PHASE:
                        prdata_d = {16'h0, cd_phase_offset_word_q};
                    DFMNCO_IDX_AB_FLO: prdata_d = {16'h0, ab_freq_word_low_q};
                    DFMNCO_IDX_AB_FHI: prdata_d = {16'h0, ab_freq_word_high_q};
                    DFMNCO_IDX_CD_FLO: prdata_d = {16'h0, cd_freq_word_low_q};
                    DFMNCO_IDX_CD_FHI: prdata_d = {16'h0, cd_freq_word_high_q};
                    DFMNCO_IDX_CTRL: prdata_d = {29'h0, sync_source_config_q};
                    DFMNCO_IDX_AB_ACT: prdata_d = ab_act_q.step;
                    DFMNCO_IDX_CD_ACT: prdata_d = cd_act_q.step;
                    DFMNCO_IDX_STAT:
                        prdata_d = {cd_act_q.shift, ab_act_q.shift};
                    default: prdata_d = 32'h0000_0000;
                endcase
            end
        end
    end

    // Register all state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ab_phase_offset_word_q <= DFMNCO_RST_WORD;
            cd_phase_offset_word_q <= DFMNCO_RST_WORD;
            ab_freq_word_low_q <= DFMNCO_RST_WORD;
            ab_freq_word_high_q <= DFMNCO_RST_WORD;
            cd_freq_word_low_q <= DFMNCO_RST_WORD;
            cd_freq_word_high_q <= DFMNCO_RST_WORD;
            sync_source_config_q <= DFMNCO_RST_CTRL;
            ab_act_q <= {DFMNCO_RST_WORD, DFMNCO_RST_FREQ};
            cd_act_q <= {DFMNCO_RST_WORD, DFMNCO_RST_FREQ};
            ab_sync_q <= 1'b0;
            cd_sync_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            ab_phase_offset_word_q <= ab_phase_offset_word_d;
            cd_phase_offset_word_q <= cd_phase_offset_word_d;
            ab_freq_word_low_q <= ab_freq_word_low_d;
            ab_freq_word_high_q <= ab_freq_word_high_d;
            cd_freq_word_low_q <= cd_freq_word_low_d;
            cd_freq_word_high_q <= cd_freq_word_high_d;
            sync_source_config_q <= sync_source_config_d;
            ab_act_q <= ab_act_d;
            cd_act_q <= cd_act_d;
            ab_sync_q <= ab_sync_d;
            cd_sync_q <= cd_sync_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign ab_sync = ab_sync_q;
    assign cd_sync = cd_sync_q;

    // AB oscillator: signed step, wrapping accumulator, offset index
    dfmnco_osc u_ab_osc (
        .pclk(pclk),
        .presetn(presetn),
        .run(sync_source_config_q[DFMNCO_CTRL_RUN_BIT]),
        .act(ab_act_q),
        .nco(ab_nco),
        .acc(ab_acc)
    );

    // CD oscillator
    dfmnco_osc u_cd_osc (
        .pclk(pclk),
        .presetn(presetn),
        .run(sync_source_config_q[DFMNCO_CTRL_RUN_BIT]),
        .act(cd_act_q),
        .nco(cd_nco),
        .acc(cd_acc)
    );
endmodule : dfmnco_top
`default_nettype wire

// ===== include/dfmnco_pkg.sv
package dfmnco_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] DFMNCO_IDX_AB_PHASE = 8'h12;
    localparam logic [7:0] DFMNCO_IDX_CD_PHASE = 8'h13;
    localparam logic [7:0] DFMNCO_IDX_AB_FLO = 8'h14;
    localparam logic [7:0] DFMNCO_IDX_AB_FHI = 8'h15;
    localparam logic [7:0] DFMNCO_IDX_CD_FLO = 8'h16;
    localparam logic [7:0] DFMNCO_IDX_CD_FHI = 8'h17;
    localparam logic [7:0] DFMNCO_IDX_CTRL = 8'h30;
    localparam logic [7:0] DFMNCO_IDX_AB_ACT = 8'h31;
    localparam logic [7:0] DFMNCO_IDX_CD_ACT = 8'h32;
    localparam logic [7:0] DFMNCO_IDX_STAT = 8'h33;
    // Reset values
    localparam logic [15:0] DFMNCO_RST_WORD = 16'h0000;
    localparam logic [31:0] DFMNCO_RST_FREQ = 32'h0000_0000;
    // Control register field positions
    localparam int DFMNCO_CTRL_SYNC_AB_BIT = 0;
    localparam int DFMNCO_CTRL_SYNC_CD_BIT = 1;
    localparam int DFMNCO_CTRL_RUN_BIT = 2;
    localparam logic [2:0] DFMNCO_RST_CTRL = 3'h3;

    // Active mixer settings of one path
    typedef struct packed {
        logic [15:0] shift;
        logic [31:0] step;
    } dfmnco_set_t;

    // Outputs of one oscillator
    typedef struct packed {
        logic [15:0] index;
        logic [15:0] sin;
        logic [15:0] cos;
    } dfmnco_out_t;
endpackage : dfmnco_pkg

// ===== design/dfmnco_osc.sv
`timescale 1ns/10ps
`default_nettype none
module dfmnco_osc
    import dfmnco_pkg::*;
(
    input wire logic pclk, // Sample clock
    input wire logic presetn, // Async reset, active low
    input wire logic run, // Accumulator advances when high
    input wire dfmnco_pkg::dfmnco_set_t act, // Active settings
    output dfmnco_pkg::dfmnco_out_t nco, // Index and sin/cos
    output logic [31:0] acc // Accumulator value
);
    logic [31:0] acc_q;
    logic [31:0] acc_d;
    logic [15:0] idx;
    logic signed [15:0] s_lut;
    logic signed [15:0] c_lut;
    dfmnco_out_t out_q;
    dfmnco_out_t out_d;

    // Phase index: offset plus top of accumulator, wraps mod 2^16
    assign idx = acc_q[31:16] + act.shift;

    // Coarse full-wave table from index top bits (8 points)
    function automatic logic signed [15:0] qsin(input logic [2:0] p);
        logic signed [15:0] v;
        v = 16'sh0000;
        case (p)
            3'h0: v = 16'sh0000;
            3'h1: v = 16'sh5a82;
            3'h2: v = 16'sh7fff;
            3'h3: v = 16'sh5a82;
            3'h4: v = 16'sh0000;
            3'h5: v = -16'sh5a82;
            3'h6: v = -16'sh7fff;
            default: v = -16'sh5a82;
        endcase
        return v;
    endfunction : qsin

    // Next accumulator and registered outputs
    always_comb
    begin
        s_lut = qsin(idx[15:13]);
        c_lut = qsin(3'(idx[15:13] + 3'h2));
        acc_d = run ? acc_q + act.step : acc_q;
        out_d.index = idx;
        out_d.sin = s_lut;
        out_d.cos = c_lut;
    end

    // Register accumulator and outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_q <= 32'h0000_0000;
            out_q <= '0;
        end
        else
        begin
            acc_q <= acc_d;
            out_q <= out_d;
        end
    end

    assign nco = out_q;
    assign acc = acc_q;
endmodule : dfmnco_osc
`default_nettype wire

// ===== verification/dfmnco_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
module dfmnco_sva
    import dfmnco_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [31:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB strobes
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire dfmnco_pkg::dfmnco_out_t ab_nco, // AB output
    input wire dfmnco_pkg::dfmnco_out_t cd_nco, // CD output
    input wire logic ab_sync, // AB sync pulse
    input wire logic cd_sync // CD sync pulse
);
    logic [2:0] ctrl_q;
    logic [2:0] ctrl_d;
    logic acc_on;
    logic wr_ab;
    logic wr_cd;
    logic mapped;
    // Access phase decode
    assign acc_on = psel && penable;
    assign wr_ab = acc_on && pwrite && paddr == 32'h0000_0048;
    assign wr_cd = acc_on && pwrite && paddr == 32'h0000_004c;
    assign mapped = paddr inside {32'h48, 32'h4c, 32'h50, 32'h54, 32'h58,
        32'h5c, 32'hc0, 32'hc4, 32'hc8, 32'hcc};
    // Shadow of the control register
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (acc_on && pwrite && paddr == 32'h0000_00c0 && pstrb[0])
            ctrl_d = pwdata[2:0];
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= DFMNCO_RST_CTRL;
        else
            ctrl_q <= ctrl_d;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_high_a: assert property (pready) else $error("pready low");
    ab_fire_a: assert property (ab_sync == $past(wr_ab && ctrl_q[0]))
        else $error("ab sync pulse wrong");
    cd_fire_a: assert property (cd_sync == $past(wr_cd && ctrl_q[1]))
        else $error("cd sync pulse wrong");
    map_ok_a: assert property (acc_on && mapped |-> !pslverr)
        else $error("error on mapped address");
    unmap_err_a: assert property (acc_on && !mapped |-> pslverr)
        else $error("no error on unmapped address");
    err_zero_a: assert property (acc_on && pslverr |-> prdata == 32'h0)
        else $error("read data on error not zero");
    ab_hold_a: assert property (!ctrl_q[2] && !$past(ctrl_q[2]) &&
        !$past(ctrl_q[2], 3) && !ab_sync && !$past(ab_sync) &&
        !$past(ab_sync, 2) && !$past(ab_sync, 3) |-> $stable(ab_nco.index))
        else $error("ab index moved while idle");
    cd_hold_a: assert property (!ctrl_q[2] && !$past(ctrl_q[2]) &&
        !$past(ctrl_q[2], 3) && !cd_sync && !$past(cd_sync) &&
        !$past(cd_sync, 2) && !$past(cd_sync, 3) |-> $stable(cd_nco.index))
        else $error("cd index moved while idle");
    ab_sync_c: cover property (ab_sync);
    cd_sync_c: cover property (cd_sync);
    err_c: cover property (acc_on && pslverr);
endmodule : dfmnco_sva
bind dfmnco_top dfmnco_sva u_dfmnco_sva (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ab_nco(ab_nco), .cd_nco(cd_nco),
    .ab_sync(ab_sync), .cd_sync(cd_sync));
`default_nettype wire

// ===== verification/tb_dfmnco_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_dfmnco_top;
    import dfmnco_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic ab_sync, cd_sync;
    logic [31:0] paddr, pwdata, prdata, rdat, r;
    logic [3:0] pstrb;
    logic [15:0] i0, c0;
    logic [15:0] m_stg [2][3];
    logic [31:0] m_act [2];
    logic [15:0] m_sh [2];
    logic [2:0] m_ctrl;
    dfmnco_out_t ab_nco, cd_nco;
    int miscompares, compares;
    dfmnco_top u_dfmnco_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ab_nco(ab_nco), .cd_nco(cd_nco), .ab_sync(ab_sync),
        .cd_sync(cd_sync));
    // Clock, 50 ns period
    initial pclk = 1'b0;
    always #25 pclk = ~pclk;
    task automatic tally_and_finish;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // One APB transfer, held until pready is seen
    task automatic apb(input logic w, input logic [31:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Wait for ready; only the watchdog ends a hang
        while (pready !== 1'b1)
            @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e,
        input logic ee);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
        chk({31'h0, rerr}, {31'h0, ee});
    endtask : rd_chk
    function automatic logic [31:0] ra(input int p, input int k);
        return (k == 0) ? 32'h48 + 32'(4 * p)
            : 32'h50 + 32'(8 * p + 4 * k - 4);
    endfunction : ra
    // Register write plus model update, offset write may sync
    task automatic wr_reg(input int p, input int k, input logic [15:0] d);
        apb(1'b1, ra(p, k), {16'h0000, d});
        m_stg[p][k] = d;
        if (k == 0 && m_ctrl[p])
        begin
            m_act[p] = {m_stg[p][2], m_stg[p][1]};
            m_sh[p] = d;
        end
    endtask : wr_reg
    task automatic wr_ctrl(input logic [2:0] c);
        apb(1'b1, 32'hc0, {29'h0, c});
        m_ctrl = c;
    endtask : wr_ctrl
    // Watchdog
    initial
    begin
        repeat (5000) @(posedge pclk);
        miscompares++;
        tally_and_finish();
    end
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        miscompares = 0;
        compares = 0;
        m_ctrl = DFMNCO_RST_CTRL;
        m_stg = '{default: '{default: 16'h0}};
        m_act = '{default: 32'h0};
        m_sh = '{default: 16'h0};
        r = $urandom(63);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int p = 0; p < 2; p++)
            for (int k = 0; k < 3; k++)
                rd_chk(ra(p, k), 32'h0, 1'b0);
        rd_chk(32'hc0, 32'h3, 1'b0);
        $display("test reset done");
        // Staged halves, then offset write loads all together
        for (int p = 0; p < 2; p++)
        begin
            wr_reg(p, 1, 16'($urandom));
            wr_reg(p, 2, 16'($urandom));
            rd_chk(32'hc4 + 32'(4 * p), m_act[p], 1'b0);
            wr_reg(p, 0, 16'($urandom));
            rd_chk(32'hc4 + 32'(4 * p), m_act[p], 1'b0);
            rd_chk(32'hcc, {m_sh[1], m_sh[0]}, 1'b0);
            for (int k = 0; k < 3; k++)
                rd_chk(ra(p, k), {16'h0, m_stg[p][k]}, 1'b0);
        end
        chk({16'h0, ab_nco.index}, {16'h0, m_sh[0]});
        chk({16'h0, cd_nco.index}, {16'h0, m_sh[1]});
        // Quarter turn apart: AB at zero phase, CD at ninety degrees
        wr_reg(0, 0, 16'h0000);
        wr_reg(1, 0, 16'h4000);
        @(posedge pclk);
        #1;
        chk({16'h0, ab_nco.sin}, 32'h0);
        chk({16'h0, cd_nco.cos}, 32'h0);
        chk({16'h0, cd_nco.sin}, {16'h0, ab_nco.cos});
        chk({31'h0, $signed(ab_nco.cos) > 16'sh0000}, 32'h1);
        $display("test sync done");
        // Sync disabled: offset write stages only
        wr_ctrl(3'h0);
        for (int p = 0; p < 2; p++)
        begin
            for (int k = 2; k >= 0; k--)
                wr_reg(p, k, 16'($urandom));
            rd_chk(32'hc4 + 32'(4 * p), m_act[p], 1'b0);
        end
        rd_chk(32'hcc, {m_sh[1], m_sh[0]}, 1'b0);
        wr_ctrl(3'h3);
        rd_chk(32'h44, 32'h0, 1'b1);
        rd_chk(32'h49, 32'h0, 1'b1);
        $display("test disable and error done");
        // Signed steps: AB up one index, CD down one index per cycle
        wr_reg(0, 1, 16'h0000);
        wr_reg(0, 2, 16'h0001);
        wr_reg(0, 0, 16'($urandom));
        wr_reg(1, 1, 16'h0000);
        wr_reg(1, 2, 16'hffff);
        wr_reg(1, 0, 16'($urandom));
        wr_ctrl(3'h7);
        repeat (4) @(posedge pclk);
        #1;
        i0 = ab_nco.index;
        c0 = cd_nco.index;
        @(posedge pclk);
        #1;
        chk({16'h0, ab_nco.index}, {16'h0, i0 + 16'h0001});
        chk({16'h0, cd_nco.index}, {16'h0, c0 - 16'h0001});
        $display("test run done");
        tally_and_finish();
    end
endmodule : tb_dfmnco_top
`default_nettype wire
